// File: design/spa_match.sv
// address recognition: given and broadcast address compare
`timescale 1ns/1ps
module spa_match
  import spa_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic [WIDTH-1:0] rx_byte,   // received data bits
  input  wire logic [WIDTH-1:0] slave_addr, // slave address
  input  wire logic [WIDTH-1:0] addr_mask,  // address mask
  output logic                  hit         // given or broadcast match
);
  logic [WIDTH-1:0] given_ok;
  logic [WIDTH-1:0] bcast_ok;
  logic [WIDTH-1:0] bcast;
  assign bcast = slave_addr | addr_mask;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign given_ok[i] = ~addr_mask[i] | (rx_byte[i] == slave_addr[i]);
      assign bcast_ok[i] = ~bcast[i] | rx_byte[i];
    end
  endgenerate
  assign hit = (&given_ok) | (&bcast_ok);
endmodule : spa_match

// File: design/spa_pkg.sv
// package: register map, field positions and timing constants of the serial port
package spa_pkg;
  localparam logic [7:0] SPA_ADDR_CTRL  = 8'h98;
  localparam logic [7:0] SPA_ADDR_BUF   = 8'h99;
  localparam logic [7:0] SPA_ADDR_PWR   = 8'h87;
  localparam logic [7:0] SPA_ADDR_SLAVE_ADDRESS_REG = 8'ha9;
  localparam logic [7:0] SPA_ADDR_MASK  = 8'hb9;
  localparam logic [7:0] SPA_RST_BYTE   = 8'h00;
  localparam int SPA_B_SM0   = 7;
  localparam int SPA_B_SM1   = 6;
  localparam int SPA_B_SM2   = 5;
  localparam int SPA_B_REN   = 4;
  localparam int SPA_B_TB8   = 3;
  localparam int SPA_B_RB8   = 2;
  localparam int SPA_B_TI    = 1;
  localparam int SPA_B_RI    = 0;
  localparam int SPA_B_DOUBLE_RATE_SELECT  = 7;
  localparam int SPA_B_STATUS_BIT_SELECT = 6;
  localparam int SPA_OSR     = 16;
  localparam logic [3:0] SPA_S8  = 4'h7;
  localparam logic [3:0] SPA_S9  = 4'h8;
  localparam logic [3:0] SPA_S10 = 4'h9;
  localparam logic [3:0] SPA_S_LAST = 4'hf;
  localparam int SPA_M0_SLOW = 12;
  localparam int SPA_M0_FAST = 4;
  localparam int SPA_M2_SLOW = 4;
  localparam int SPA_M2_FAST = 2;
  localparam int SPA_T1_SLOW = 2;
  localparam int SPA_T1_FAST = 1;
  localparam logic [3:0] SPA_BITS8  = 4'h8;
  localparam logic [3:0] SPA_BITS10 = 4'ha;
  localparam logic [3:0] SPA_BITS11 = 4'hb;
  localparam logic [1:0] SPA_MODE0 = 2'h0;
  localparam logic [1:0] SPA_MODE1 = 2'h1;
  localparam logic [1:0] SPA_MODE2 = 2'h2;
  localparam logic [1:0] SPA_MODE3 = 2'h3;
  localparam logic [1:0] SPA_RESP_OK  = 2'h0;
  localparam logic [1:0] SPA_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {SPA_IDLE, SPA_START, SPA_DATA} spa_rx_t;
endpackage : spa_pkg

// File: design/spa_serial_port.sv
// serial port core with four modes, frame error and address recognition
`timescale 1ns/1ps
module spa_serial_port
  import spa_pkg::*;
(
  input  wire logic        core_clk,      // 40 MHz clock
  input  wire logic        resetn,        // async reset, active low
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic        timer1_ovf,    // timer 1 overflow pulse
  input  wire logic        rxd_in,        // serial data pin input
  output logic             rxd_out,       // serial data pin output
  output logic             rxd_oe_n,      // serial data pin enable, low drives
  output logic             txd_out        // transmit data or shift clock
);
  logic [7:0] ctrl_reg;
  logic [7:0] pwr_reg;
  logic [7:0] slave_address_reg;
  logic [7:0] slave_address_mask_reg;
  logic [7:0] rx_buf_reg;
  logic       mode_hi_reg;
  logic       fe_reg;
  logic [1:0] mode;
  logic       status_bit_select;
  assign mode  = {mode_hi_reg, ctrl_reg[SPA_B_SM1]};
  assign status_bit_select = pwr_reg[SPA_B_STATUS_BIT_SELECT];

  // ---- bus slave
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_idx;
  logic [31:0] w_data;
  logic        w_strb0;
  logic        do_wr;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_idx;
  logic [7:0]  rd_val;
  assign do_wr  = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_hit = (aw_idx == SPA_ADDR_CTRL) | (aw_idx == SPA_ADDR_BUF) |
                  (aw_idx == SPA_ADDR_PWR) | (aw_idx == SPA_ADDR_SLAVE_ADDRESS_REG) |
                  (aw_idx == SPA_ADDR_MASK);
  assign rd_idx = s_axi_araddr[9:2];
  assign rd_hit = (rd_idx == SPA_ADDR_CTRL) | (rd_idx == SPA_ADDR_BUF) |
                  (rd_idx == SPA_ADDR_PWR) | (rd_idx == SPA_ADDR_SLAVE_ADDRESS_REG) |
                  (rd_idx == SPA_ADDR_MASK);
  logic wr_ctrl;
  logic wr_buf;
  logic wr_pwr;
  assign wr_ctrl = do_wr & w_strb0 & (aw_idx == SPA_ADDR_CTRL);
  assign wr_buf  = do_wr & w_strb0 & (aw_idx == SPA_ADDR_BUF);
  assign wr_pwr  = do_wr & w_strb0 & (aw_idx == SPA_ADDR_PWR);

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_idx  <= SPA_RST_BYTE;
      w_data  <= 32'h0;
      w_strb0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= SPA_RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_idx  <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_strb0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? SPA_RESP_OK : SPA_RESP_ERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_hold       <= 1'b0;
        w_hold        <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end

  always_comb
  begin
    case (rd_idx)
      SPA_ADDR_CTRL:  rd_val = {status_bit_select ? fe_reg : mode_hi_reg,
                                ctrl_reg[6:0]};
      SPA_ADDR_BUF:   rd_val = rx_buf_reg;
      SPA_ADDR_PWR:   rd_val = pwr_reg;
      SPA_ADDR_SLAVE_ADDRESS_REG: rd_val = slave_address_reg;
      SPA_ADDR_MASK:  rd_val = slave_address_mask_reg;
      default:        rd_val = SPA_RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= SPA_RESP_OK;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h0, rd_val};
      s_axi_rresp   <= rd_hit ? SPA_RESP_OK : SPA_RESP_ERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end

  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      pwr_reg <= SPA_RST_BYTE;
      slave_address_reg      <= SPA_RST_BYTE;
      slave_address_mask_reg <= SPA_RST_BYTE;
    end
    else if (do_wr & w_strb0)
    begin
      if (aw_idx == SPA_ADDR_PWR)   pwr_reg <= w_data[7:0];
      if (aw_idx == SPA_ADDR_SLAVE_ADDRESS_REG) slave_address_reg <= w_data[7:0];
      if (aw_idx == SPA_ADDR_MASK)  slave_address_mask_reg <= w_data[7:0];
    end

  // ---- baud ticks: tick16 is the 16x sample tick in async modes
  logic [5:0] pre_cnt;
  logic [5:0] pre_div;
  logic       t1_half;
  logic       tick16;
  logic       m0_tick;
  logic [3:0] m0_cnt;
  logic [3:0] m0_div;
  assign pre_div = 6'((mode == SPA_MODE2) ?
                   (pwr_reg[SPA_B_DOUBLE_RATE_SELECT] ? SPA_M2_FAST : SPA_M2_SLOW) : 1);
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      pre_cnt <= 6'h0;
      t1_half <= 1'b0;
    end
    else if (mode == SPA_MODE2)
    begin
      pre_cnt <= (pre_cnt >= pre_div - 6'h1) ? 6'h0 : pre_cnt + 6'h1;
    end
    else if (timer1_ovf)
      t1_half <= ~t1_half;
  // timer-driven: 16x tick on each overflow (double rate) or every second one
  assign tick16 = (mode == SPA_MODE2) ? (pre_cnt == 6'h0) :
                  (timer1_ovf & (pwr_reg[SPA_B_DOUBLE_RATE_SELECT] | t1_half));

  // each half of the shift clock lasts half of the bit time
  assign m0_div = 4'((ctrl_reg[SPA_B_SM2] ? SPA_M0_FAST : SPA_M0_SLOW) /
                     2);
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
      m0_cnt <= 4'h0;
    else
      m0_cnt <= (m0_cnt >= m0_div - 4'h1) ? 4'h0 : m0_cnt + 4'h1;
  assign m0_tick = (m0_cnt == 4'h0);

  // ---- transmitter
  logic [10:0] tx_sh;
  logic [3:0]  tx_left;
  logic [3:0]  tx_ph;
  logic        tx_busy;
  logic        tx_done;
  logic        m0_rx_busy;
  logic [3:0]  m0_left;
  logic [7:0]  m0_sh;
  logic        m0_rx_done;
  logic        m0_clk_low;
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_ph <= 4'h0;
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
      m0_clk_low <= 1'b0;
    end
    else
    begin
      tx_done <= 1'b0;
      if (wr_buf)
      begin
        tx_busy <= 1'b1;
        tx_ph   <= 4'h0;
        if (mode == SPA_MODE0)
        begin
          tx_sh   <= {3'h7, w_data[7:0]};
          tx_left <= SPA_BITS8;
        end
        else if (mode == SPA_MODE1)
        begin
          tx_sh   <= {2'h3, w_data[7:0], 1'b0};
          tx_left <= SPA_BITS10;
        end
        else
        begin
          tx_sh   <= {1'b1, ctrl_reg[SPA_B_TB8], w_data[7:0], 1'b0};
          tx_left <= SPA_BITS11;
        end
      end
      else if (tx_busy & (mode == SPA_MODE0) & m0_tick)
      begin // low half then high half; data moves on the falling edge
        m0_clk_low <= ~m0_clk_low;
        // keeps each bit steady across the rising edge the far end latches on
        if (!m0_clk_low & (tx_left != SPA_BITS8))
          tx_sh <= {1'b1, tx_sh[10:1]};
        if (m0_clk_low)
        begin
          tx_left <= tx_left - 4'h1;
          if (tx_left == 4'h1)
          begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
          end
        end
      end
      else if (tx_busy & (mode != SPA_MODE0) & tick16)
      begin
        tx_ph <= tx_ph + 4'h1;
        if (tx_ph == SPA_S_LAST)
        begin
          tx_sh   <= {1'b1, tx_sh[10:1]};
          tx_left <= tx_left - 4'h1;
          if (tx_left == 4'h1)
          begin
            tx_busy <= 1'b0;
            tx_done <= 1'b1;
          end
        end
      end
      else if (m0_rx_busy & m0_tick)
        m0_clk_low <= ~m0_clk_low;
      else if (!tx_busy & !m0_rx_busy)
        m0_clk_low <= 1'b0;
    end

  // ---- mode 0 receive: starts on rx done clear and receive enable
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      m0_rx_busy <= 1'b0;
      m0_left <= 4'h0;
      m0_sh <= 8'h0;
      m0_rx_done <= 1'b0;
    end
    else
    begin
      m0_rx_done <= 1'b0;
      if (mode != SPA_MODE0)
        m0_rx_busy <= 1'b0;
      else if (!m0_rx_busy & !tx_busy & !ctrl_reg[SPA_B_RI] &
               ctrl_reg[SPA_B_REN])
      begin
        m0_rx_busy <= 1'b1;
        m0_left <= SPA_BITS8;
      end
      else if (m0_rx_busy & m0_tick & m0_clk_low)
      begin // latch on the rising shift clock
        m0_sh   <= {rxd_in, m0_sh[7:1]};
        m0_left <= m0_left - 4'h1;
        if (m0_left == 4'h1)
        begin
          m0_rx_busy <= 1'b0;
          m0_rx_done <= 1'b1;
        end
      end
    end

  // ---- async receiver
  spa_rx_t    rx_st;
  logic       rxd_d;
  logic [3:0] rx_ph;
  logic [2:0] vote;
  logic       bit_v;
  logic [3:0] rx_cnt;
  logic [9:0] rx_sh;
  logic       rx_end;
  logic       addr_hit;
  logic       ninth;
  logic       stop_ok;
  logic       accept;
  assign bit_v = (vote[0] & vote[1]) | (vote[0] & rxd_in) |
                 (vote[1] & rxd_in);
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      rx_st <= SPA_IDLE;
      rxd_d <= 1'b1;
      rx_ph <= 4'h0;
      vote <= 3'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 10'h0;
      rx_end <= 1'b0;
    end
    else
    begin
      rx_end <= 1'b0;
      if (tick16)
        rxd_d <= rxd_in;
      case (rx_st)
        SPA_IDLE:
          if (tick16 & rxd_d & !rxd_in & ctrl_reg[SPA_B_REN] &
              (mode != SPA_MODE0))
          begin
            rx_st <= SPA_START;
            rx_ph <= 4'h0;
          end
        SPA_START, SPA_DATA:
          if (!ctrl_reg[SPA_B_REN] | (mode == SPA_MODE0))
            rx_st <= SPA_IDLE;
          else if (tick16)
          begin
            rx_ph <= rx_ph + 4'h1;
            if (rx_ph == SPA_S8)
              vote[0] <= rxd_in;
            if (rx_ph == SPA_S9)
              vote[1] <= rxd_in;
            if (rx_ph == SPA_S10)
            begin
              if (rx_st == SPA_START)
              begin
                rx_st  <= bit_v ? SPA_IDLE : SPA_DATA;
                rx_cnt <= 4'h0;
              end
              else
              begin
                rx_sh  <= {bit_v, rx_sh[9:1]};
                rx_cnt <= rx_cnt + 4'h1;
                // end at middle of stop bit
                if (rx_cnt == ((mode == SPA_MODE1) ? SPA_BITS8 : 4'h9))
                begin
                  rx_st  <= SPA_IDLE;
                  rx_end <= 1'b1;
                end
              end
            end
          end
        default: rx_st <= SPA_IDLE;
      endcase
    end
  // rx_sh after the end: mode 1 {stop,d7..d0,x}, modes 2/3 {stop,b9,d7..d0}
  logic [7:0] rx_byte;
  assign rx_byte = (mode == SPA_MODE1) ? rx_sh[8:1] : rx_sh[7:0];
  assign ninth   = (mode == SPA_MODE1) ? rx_sh[9] : rx_sh[8];
  assign stop_ok = rx_sh[9];

  spa_match #(.WIDTH(8)) u_match (
    .rx_byte    (rx_byte),
    .slave_addr (slave_address_reg),
    .addr_mask  (slave_address_mask_reg),
    .hit        (addr_hit)
  );
  assign accept = !ctrl_reg[SPA_B_RI] &
                  (!ctrl_reg[SPA_B_SM2] |
                   (ninth & stop_ok & addr_hit));

  // ---- control register, mode high bit, frame error
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      ctrl_reg <= SPA_RST_BYTE;
      mode_hi_reg <= 1'b0;
      fe_reg <= 1'b0;
      rx_buf_reg <= SPA_RST_BYTE;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg <= w_data[7:0];
        if (status_bit_select)
          fe_reg <= w_data[SPA_B_SM0];
        else
          mode_hi_reg <= w_data[SPA_B_SM0];
      end
      if (rx_end & !stop_ok)
        fe_reg <= 1'b1;
      if (tx_done)
        ctrl_reg[SPA_B_TI] <= 1'b1;
      if (m0_rx_done)
      begin
        rx_buf_reg <= m0_sh;
        ctrl_reg[SPA_B_RI] <= 1'b1;
      end
      if (rx_end & accept)
      begin
        rx_buf_reg <= rx_byte;
        ctrl_reg[SPA_B_RB8] <= (mode == SPA_MODE1) ? stop_ok : ninth;
        ctrl_reg[SPA_B_RI] <= 1'b1;
      end
    end

  // ---- pins
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      rxd_out  <= 1'b1;
      rxd_oe_n <= 1'b1;
      txd_out  <= 1'b1;
    end
    else if (mode == SPA_MODE0)
    begin
      rxd_out  <= tx_sh[0];
      rxd_oe_n <= ~tx_busy;
      txd_out  <= ~m0_clk_low;
    end
    else
    begin
      rxd_out  <= 1'b1;
      rxd_oe_n <= 1'b1;
      txd_out  <= tx_busy ? tx_sh[0] : 1'b1;
    end
endmodule : spa_serial_port

// File: verification/spa_serial_peer.sv
// far-end serial device: sends asynchronous frames on the data pin
`timescale 1ns/1ps
module spa_serial_peer (
  input  wire logic core_clk, // clock
  output logic      line      // serial line, driven high when idle
);
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine,
                      input logic b9, input logic stop, input int bt);
    logic [10:0] f;
    f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      @(posedge core_clk);
      line <= f[i];
      repeat (bt - 1) @(posedge core_clk);
    end
    @(posedge core_clk);
    line <= 1'b1;
    repeat (bt) @(posedge core_clk);
  endtask : send
endmodule : spa_serial_peer

// File: verification/spa_serial_port_assertions.sv
// checker: bus handshake, idle levels and shift clock timing of the port
`timescale 1ns/1ps
module spa_checker
  import spa_pkg::*;
(
  input  wire logic        core_clk,      // clock
  input  wire logic        resetn,        // async reset, active low
  input  wire logic [31:0] s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  input  wire logic        s_axi_awready, // write address ready
  input  wire logic        s_axi_wready,  // write data ready
  input  wire logic        s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [31:0] s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  input  wire logic        s_axi_arready, // read address ready
  input  wire logic [31:0] s_axi_rdata,   // read data
  input  wire logic [1:0]  s_axi_rresp,   // read response
  input  wire logic        s_axi_rvalid,  // read valid
  input  wire logic        s_axi_rready,  // read ready
  input  wire logic        rxd_oe_n,      // data pin enable, low drives
  input  wire logic        txd_out        // tx line or shift clock
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic bad_rd;
  assign bad_rd = !(s_axi_araddr inside
    {32'h260, 32'h264, 32'h21c, 32'h2a4, 32'h2e4});
  property p_reset_idle;
    $rose(resetn) |-> txd_out && rxd_oe_n && s_axi_awready;
  endproperty
  property p_tx_start;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == 32'h264
      |-> ##[1:1000] !txd_out;
  endproperty
  // low half of the mode 0 shift clock lasts 2 or 6 clocks
  property p_shift_low;
    $fell(txd_out) && !rxd_oe_n |-> (!txd_out)[*2] ##1
      (txd_out or ((!txd_out)[*4] ##1 txd_out));
  endproperty
  property p_b_after;
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_b_release;
    s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_bad_read;
    s_axi_arvalid && s_axi_arready && bad_rd
      |=> s_axi_rresp == SPA_RESP_ERR && s_axi_rdata == 32'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("lines not idle after reset");
  a_tx_start: assert property (p_tx_start)
    else $error("buffer write started no transfer");
  a_shift_low: assert property (p_shift_low)
    else $error("shift clock low half has wrong length");
  a_b_after: assert property (p_b_after)
    else $error("write response before both channels taken");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  a_b_release: assert property (p_b_release)
    else $error("write response not released");
  a_r_answer: assert property (p_r_answer)
    else $error("read data late");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  a_bad_read: assert property (p_bad_read)
    else $error("unmapped read not refused");
  c_shift: cover property ($fell(txd_out) && !rxd_oe_n);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_refuse: cover property (s_axi_rvalid && s_axi_rresp == SPA_RESP_ERR);
endmodule : spa_checker

bind spa_serial_port spa_checker chk_u (
  .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rxd_oe_n, .txd_out
);

// File: verification/tb_serial_port_addr_recognition.sv
// testbench: registers, reception, framing, address filter, shift mode
`timescale 1ns/1ps
module tb_serial_port_addr_recognition
  import spa_pkg::*;
;
  localparam logic [7:0] own_idx = 8'ha9;
  logic        core_clk, resetn, timer1_ovf, rxd_in, rxd_out, rxd_oe_n;
  logic        txd_out, peer_line;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          mismatches, checked, cycles;

  spa_serial_port dut_u (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer1_ovf(timer1_ovf), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));
  spa_serial_peer peer_u (.core_clk(core_clk), .line(peer_line));
  // shared data pin: the port wins while it drives
  assign rxd_in = rxd_oe_n ? peer_line : rxd_out;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge core_clk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    while (!s_axi_rvalid);
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic t_regs;
    rd(own_idx);
    chk(rv, 32'h0);
    rd(SPA_ADDR_MASK);
    chk(rv, 32'h0);
    wr(own_idx, 8'h5c);
    rd(own_idx);
    chk(rv, 32'h5c);
    rd(8'hc0);
    chk({30'h0, resp}, {30'h0, SPA_RESP_ERR});
    wr(8'hc0, 8'h55);
    chk({30'h0, resp}, {30'h0, SPA_RESP_ERR});
  endtask : t_regs

  // receive one frame, then send one and time the transmit done flag
  task automatic t_rx_plain(input logic [7:0] pwr, input logic [7:0] ctrl,
                            input int bt);
    wr(SPA_ADDR_PWR, pwr);
    wr(SPA_ADDR_CTRL, ctrl);
    peer_u.send(8'h5a, 1'b1, 1'b0, 1'b1, bt);
    rd(SPA_ADDR_CTRL);
    chk(rv, {24'h0, ctrl | 8'h01});
    rd(SPA_ADDR_BUF);
    chk(rv, 32'h5a);
    wr(SPA_ADDR_BUF, 8'h81);
    repeat (bt * 10) @(posedge core_clk);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[1]}, 32'h0);
    repeat (bt * 2) @(posedge core_clk);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[1]}, 32'h1);
  endtask : t_rx_plain

  task automatic t_frame_err;
    wr(SPA_ADDR_PWR, 8'hc0);
    wr(SPA_ADDR_CTRL, 8'h10);
    peer_u.send(8'h33, 1'b1, 1'b0, 1'b0, 32);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[7]}, 32'h1);
    wr(SPA_ADDR_PWR, 8'h80);
    wr(SPA_ADDR_CTRL, 8'h90);
    peer_u.send(8'h3c, 1'b1, 1'b0, 1'b1, 32);
    rd(SPA_ADDR_CTRL);
    chk(rv, 32'h91);
    wr(SPA_ADDR_PWR, 8'hc0);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[7]}, 32'h1);
    wr(SPA_ADDR_CTRL, 8'h10);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[7]}, 32'h0);
    wr(SPA_ADDR_PWR, 8'h80);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[7]}, 32'h1);
  endtask : t_frame_err

  // entry: control value, byte, ninth used, ninth value, accept expected
  task automatic t_filter;
    logic [18:0] tab [12] = '{{8'hb0, 8'ha0, 3'b111}, {8'hb0, 8'ha5, 3'b111},
      {8'hb0, 8'ha2, 3'b110}, {8'hb0, 8'ha8, 3'b110},
      {8'hb0, 8'hff, 3'b111}, {8'hb0, 8'hfe, 3'b111},
      {8'hb0, 8'ha0, 3'b100}, {8'hf0, 8'ha0, 3'b111},
      {8'hf0, 8'ha2, 3'b110}, {8'h70, 8'ha0, 3'b001},
      {8'h70, 8'ha2, 3'b000}, {8'hd0, 8'h33, 3'b101}};
    wr(own_idx, 8'ha4);
    wr(SPA_ADDR_MASK, 8'hfa);
    for (int i = 0; i < 12; i++)
    begin
      wr(SPA_ADDR_CTRL, tab[i][18:11]);
      peer_u.send(tab[i][10:3], tab[i][2], tab[i][1], 1'b1, 32);
      rd(SPA_ADDR_CTRL);
      chk({31'h0, rv[0]}, {31'h0, tab[i][0]});
      rd(SPA_ADDR_BUF);
      if (tab[i][0])
        chk(rv, {24'h0, tab[i][10:3]});
    end
  endtask : t_filter

  task automatic t_shift(input logic [7:0] ctrl, input logic [7:0] d,
                         input int period);
    logic [7:0] got;
    logic       prev;
    int         rises;
    int         gap;
    int         last;
    got = 8'h0;
    prev = 1'b1;
    rises = 0;
    gap = 0;
    last = 0;
    wr(SPA_ADDR_CTRL, ctrl);
    wr(SPA_ADDR_BUF, d);
    repeat (300)
    begin
      @(posedge core_clk);
      gap++;
      if (!prev && txd_out)
      begin
        got = {rxd_out, got[7:1]};
        last = gap;
        gap = 0;
        rises++;
      end
      prev = txd_out;
    end
    chk(rises, 32'h8);
    chk({24'h0, got}, {24'h0, d});
    chk(last, period);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[1]}, 32'h1);
  endtask : t_shift

  // mode 0 receive starts by itself; the idle line gives all ones
  task automatic t_m0_rx;
    wr(SPA_ADDR_CTRL, 8'h30);
    repeat (60) @(posedge core_clk);
    rd(SPA_ADDR_CTRL);
    chk({31'h0, rv[0]}, 32'h1);
    rd(SPA_ADDR_BUF);
    chk(rv, 32'hff);
  endtask : t_m0_rx

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end

  // timer 1 overflows every second clock
  always @(posedge core_clk)
    timer1_ovf <= resetn && !timer1_ovf;

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      close_out;
    end
  end

  initial
  begin
    {resetn, timer1_ovf, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, mismatches, checked, cycles} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'h1;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_rx_plain(8'h80, 8'h90, 32);
    t_rx_plain(8'h00, 8'h90, 64);
    t_rx_plain(8'h00, 8'hd0, 64);
    t_frame_err;
    t_filter;
    t_shift(8'h20, 8'h96, 4);
    t_shift(8'h00, 8'h5a, 12);
    t_m0_rx;
    close_out;
  end
endmodule : tb_serial_port_addr_recognition
